// ==== core/eac_map.vh ====
`ifndef EAC_MAP_VH
`define EAC_MAP_VH
// ----------------------------------------
// register indices, byte address = index * 4
// ----------------------------------------
`define EAC_IDX_STATE     6'h20
`define EAC_IDX_LOCATION  6'h21
`define EAC_IDX_OPCODE    6'h22
`define EAC_IDX_BUFFER    6'h23
// ----------------------------------------
// fields and values
// ----------------------------------------
`define EAC_BIT_XFER      11
`define EAC_BIT_CSTORE    10
`define EAC_BIT_CLOAD     9
`define EAC_BIT_PRESENT   8
`define EAC_OPC_WRITE     4'h4
`define EAC_OPC_READ      4'h8
`define EAC_RST_BYTE      8'h00
`define EAC_RESP_OKAY     2'h0
`define EAC_RESP_SLVERR   2'h2
// serial instruction bytes sent to the memory
`define EAC_INS_WRITE     8'h02
`define EAC_INS_READ      8'h03
// ----------------------------------------
// timing
// ----------------------------------------
`define EAC_CLK_NS        25
`define EAC_SCK_HALF_NS   100
// half period in clocks: 100 ns rounded up to whole 25 ns clocks
`define EAC_SCK_HALF_CYC  3'h4
`define EAC_FRAME_BITS    5'h18
`endif

// ==== core/eac_serial.v ====
`timescale 1ns/1ps
`default_nettype none
`include "eac_map.vh"
module eac_serial (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        start,
    input  wire        is_read,
    input  wire [7:0]  addr,
    input  wire [7:0]  wdata,
    output wire        busy,
    output reg         done_r,
    output reg  [7:0]  rdata_r,
    output reg         eep_cs_n_r,
    output reg         eep_sck_r,
    output reg         eep_mosi_r,
    input  wire        eep_miso
);
    // ----------------------------------------
    // states and constants
    // ----------------------------------------
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_SHIFT = 2'h1;
    localparam [1:0] ST_END   = 2'h2;
    localparam [2:0] HALF_LAST = `EAC_SCK_HALF_CYC - 3'h1;
    localparam [4:0] BIT_LAST  = `EAC_FRAME_BITS - 5'h01;

    reg [1:0]  state_r;
    reg [2:0]  div_r;
    reg [4:0]  bit_r;
    reg [23:0] tx_r;
    reg [7:0]  rx_r;
    reg        miso_s1_r;
    reg        miso_s2_r;
    wire [23:0] frame_w;

    assign busy    = (state_r != ST_IDLE);
    assign frame_w = {(is_read ? `EAC_INS_READ : `EAC_INS_WRITE), addr, wdata};

    // two stage sync, only the second stage is read
    always @(posedge aclk) begin
        if (!aresetn) begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else begin
            miso_s1_r <= eep_miso;
            miso_s2_r <= miso_s1_r;
        end
    end

    // mode 0 frame: instruction, address, data, msb first
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r    <= ST_IDLE;
            div_r      <= 3'h0;
            bit_r      <= 5'h00;
            tx_r       <= 24'h000000;
            rx_r       <= 8'h00;
            rdata_r    <= `EAC_RST_BYTE;
            done_r     <= 1'b0;
            eep_cs_n_r <= 1'b1;
            eep_sck_r  <= 1'b0;
            eep_mosi_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        tx_r       <= frame_w;
                        eep_mosi_r <= frame_w[23];
                        eep_cs_n_r <= 1'b0;
                        div_r      <= 3'h0;
                        bit_r      <= 5'h00;
                        state_r    <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (div_r == HALF_LAST) begin
                        div_r     <= 3'h0;
                        eep_sck_r <= ~eep_sck_r;
                        if (!eep_sck_r) begin
                            rx_r <= {rx_r[6:0], miso_s2_r};
                        end else if (bit_r == BIT_LAST) begin
                            state_r <= ST_END;
                        end else begin
                            tx_r       <= {tx_r[22:0], 1'b0};
                            eep_mosi_r <= tx_r[22];
                            bit_r      <= bit_r + 5'h01;
                        end
                    end else begin
                        div_r <= div_r + 3'h1;
                    end
                end
                ST_END: begin
                    // hold chip select one half period after the last edge
                    if (div_r == HALF_LAST) begin
                        eep_cs_n_r <= 1'b1;
                        eep_mosi_r <= 1'b0;
                        rdata_r    <= rx_r;
                        done_r     <= 1'b1;
                        state_r    <= ST_IDLE;
                    end else begin
                        div_r <= div_r + 3'h1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== core/eac_top.v ====
// Behaviour
// RQ1: software puts the byte to be programmed into the byte buffer before it writes the opcode.
// RQ2: when a read from the memory ends, the returned byte is stored in the 8-bit byte buffer for software.
// RQ3: software leaves buffer, location and opcode alone while any in-progress flag is set.
// RQ4: software loads the 8-bit target location first and only then writes the opcode.
// RQ5: a write to the 4-bit opcode field starts one access with the location and buffer already loaded.
// RQ6: opcode 0x4 programs the buffer byte at the location, opcode 0x8 reads from the location.
// RQ7: after reset the byte buffer and the location register both hold zero.
// RQ8: the state register shows transfer, config store and config load busy flags, and no command starts while any is set.
`timescale 1ns/1ps
`default_nettype none
`include "eac_map.vh"
module eac_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        cfg_store_req,
    input  wire        cfg_load_req,
    input  wire [7:0]  cfg_addr,
    input  wire [7:0]  cfg_wdata,
    output reg  [7:0]  cfg_rdata_r,
    output reg         cfg_done_r,
    input  wire        eep_present_pin,
    output wire        eep_cs_n,
    output wire        eep_sck,
    output wire        eep_mosi,
    input  wire        eep_miso
);
    // ----------------------------------------
    // kinds of transfer
    // ----------------------------------------
    localparam [1:0] KIND_SW_WR = 2'h0;
    localparam [1:0] KIND_SW_RD = 2'h1;
    localparam [1:0] KIND_CSTORE = 2'h2;
    localparam [1:0] KIND_CLOAD = 2'h3;

    reg        aw_hold_r;
    reg        w_hold_r;
    reg [5:0]  aw_idx_r;
    reg [31:0] wdata_r;
    reg        wstrb0_r;
    reg [7:0]  location_r;
    reg [7:0]  byte_buffer_r;
    reg        xfer_busy_r;
    reg        cstore_busy_r;
    reg        cload_busy_r;
    reg [1:0]  kind_r;
    reg        present_s1_r;
    reg        present_s2_r;
    reg [31:0] rd_word;
    reg        rd_hit;
    reg        wr_hit;
    reg        opc_known;
    reg [15:0] state_word;

    wire       do_wr;
    wire       any_busy;
    wire [5:0] ar_idx;
    wire [3:0] opc_field;
    wire       wr_ok;
    wire       loc_we;
    wire       buf_we;
    wire       opc_we;
    wire       sw_go;
    wire       cstore_go;
    wire       cload_go;
    wire       eng_start;
    wire       eng_read;
    wire [7:0] eng_addr;
    wire [7:0] eng_wdata;
    wire       eng_busy;
    wire       eng_done;
    wire [7:0] eng_rdata;
    wire [1:0] kind_nxt;

    // ----------------------------------------
    // axi4-lite write channels
    // ----------------------------------------
    // address and data are taken in either order, response waits for both
    // prot bits and strobe lanes above lane 0 are ignored, only lane 0 carries data
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign do_wr         = aw_hold_r && w_hold_r && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_idx_r  <= 6'h00;
            wdata_r   <= 32'h00000000;
            wstrb0_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_idx_r  <= s_axi_awaddr[7:2];
            end else if (do_wr) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end else if (do_wr) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    always @* begin
        wr_hit = (aw_idx_r == `EAC_IDX_LOCATION) || (aw_idx_r == `EAC_IDX_OPCODE) ||
                 (aw_idx_r == `EAC_IDX_BUFFER) || (aw_idx_r == `EAC_IDX_STATE);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EAC_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `EAC_RESP_OKAY : `EAC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // opcode and register write decode
    // ----------------------------------------
    assign any_busy  = xfer_busy_r || cstore_busy_r || cload_busy_r || eng_busy;
    assign opc_field = wdata_r[3:0];

    // unknown opcodes are dropped without a transfer
    always @* begin
        case (opc_field)
            `EAC_OPC_WRITE: opc_known = 1'b1; // RQ6
            `EAC_OPC_READ:  opc_known = 1'b1; // RQ6
            default:        opc_known = 1'b0;
        endcase
    end

    // writes while busy are dropped so an access in flight keeps its operands
    assign wr_ok     = do_wr && wstrb0_r && !any_busy; // RQ8
    assign loc_we    = wr_ok && (aw_idx_r == `EAC_IDX_LOCATION);
    assign buf_we    = wr_ok && (aw_idx_r == `EAC_IDX_BUFFER);
    assign opc_we    = wr_ok && (aw_idx_r == `EAC_IDX_OPCODE); // RQ5
    assign sw_go     = opc_we && opc_known; // RQ5 RQ8

    // ----------------------------------------
    // command launch
    // ----------------------------------------
    // software wins a tie, then store over load
    assign cstore_go = cfg_store_req && !sw_go && !any_busy; // RQ8
    assign cload_go  = cfg_load_req && !cfg_store_req && !sw_go && !any_busy; // RQ8

    assign eng_start = sw_go || cstore_go || cload_go;
    assign eng_read  = sw_go ? (opc_field == `EAC_OPC_READ) : cload_go; // RQ6
    // the access uses what is already loaded, so location and buffer must be loaded before the opcode write
    assign eng_addr  = sw_go ? location_r : cfg_addr; // RQ4 RQ5
    assign eng_wdata = sw_go ? byte_buffer_r : cfg_wdata; // RQ1 RQ5
    // the kind decides where the result of this frame goes when it ends
    assign kind_nxt  = sw_go ? (eng_read ? KIND_SW_RD : KIND_SW_WR) : (cstore_go ? KIND_CSTORE : KIND_CLOAD);

    eac_serial u_serial (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .start      (eng_start),
        .is_read    (eng_read),
        .addr       (eng_addr),
        .wdata      (eng_wdata),
        .busy       (eng_busy),
        .done_r     (eng_done),
        .rdata_r    (eng_rdata),
        .eep_cs_n_r (eep_cs_n),
        .eep_sck_r  (eep_sck),
        .eep_mosi_r (eep_mosi),
        .eep_miso   (eep_miso)
    );

    // ----------------------------------------
    // busy flags
    // ----------------------------------------
    // flags stay set through the whole frame; the memory's own write cycle is not covered
    always @(posedge aclk) begin
        if (!aresetn) begin
            xfer_busy_r   <= 1'b0;
            cstore_busy_r <= 1'b0;
            cload_busy_r  <= 1'b0;
            kind_r        <= KIND_SW_WR;
        end else if (eng_start) begin
            xfer_busy_r   <= 1'b1; // RQ8
            cstore_busy_r <= cstore_go; // RQ8
            cload_busy_r  <= cload_go; // RQ8
            kind_r        <= kind_nxt;
        end else if (eng_done) begin
            xfer_busy_r   <= 1'b0;
            cstore_busy_r <= 1'b0;
            cload_busy_r  <= 1'b0;
        end
    end

    // ----------------------------------------
    // location and byte buffer
    // ----------------------------------------
    // a read result beats a buffer write in the same cycle, which busy refuses anyway
    always @(posedge aclk) begin
        if (!aresetn) begin
            location_r    <= `EAC_RST_BYTE; // RQ7
            byte_buffer_r <= `EAC_RST_BYTE; // RQ7
        end else begin
            if (loc_we) begin
                location_r <= wdata_r[7:0];
            end
            if (eng_done && (kind_r == KIND_SW_RD)) begin
                byte_buffer_r <= eng_rdata; // RQ2
            end else if (buf_we) begin
                byte_buffer_r <= wdata_r[7:0];
            end
        end
    end

    // ----------------------------------------
    // config request port
    // ----------------------------------------
    // a request seen while busy is lost, the requester waits for cfg_done_r
    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg_rdata_r <= `EAC_RST_BYTE;
            cfg_done_r  <= 1'b0;
        end else begin
            cfg_done_r <= eng_done && ((kind_r == KIND_CSTORE) || (kind_r == KIND_CLOAD));
            if (eng_done && (kind_r == KIND_CLOAD)) begin
                cfg_rdata_r <= eng_rdata;
            end
        end
    end

    // ----------------------------------------
    // presence pin sync
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            present_s1_r <= 1'b0;
            present_s2_r <= 1'b0;
        end else begin
            present_s1_r <= eep_present_pin;
            present_s2_r <= present_s1_r;
        end
    end

    // ----------------------------------------
    // axi4-lite read channels
    // ----------------------------------------
    // unused bits read as zero
    always @* begin
        state_word                   = 16'h0000;
        state_word[`EAC_BIT_XFER]    = xfer_busy_r; // RQ8
        state_word[`EAC_BIT_CSTORE]  = cstore_busy_r; // RQ8
        state_word[`EAC_BIT_CLOAD]   = cload_busy_r; // RQ8
        state_word[`EAC_BIT_PRESENT] = present_s2_r;
    end

    assign ar_idx        = s_axi_araddr[7:2];
    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (ar_idx)
            `EAC_IDX_STATE:    rd_word = {16'h0000, state_word};
            `EAC_IDX_LOCATION: rd_word = {24'h000000, location_r};
            `EAC_IDX_OPCODE:   rd_word = 32'h00000000;
            `EAC_IDX_BUFFER:   rd_word = {24'h000000, byte_buffer_r}; // RQ2
            default:           rd_hit  = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `EAC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `EAC_RESP_OKAY : `EAC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== sim/eac_eeprom_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// serial memory, mode 0, 24-bit frames
// ----------------------------------------
module eac_eeprom_model (
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic mosi,
    output var  logic miso
);
    logic [7:0]  mem [0:255];
    logic [23:0] sh;
    logic [7:0]  ins;
    logic [7:0]  adr;
    int          cnt;
    initial begin
        miso = 1'b0;
        cnt = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    end
    always @(negedge cs_n) cnt = 0;
    always @(posedge sck) if (!cs_n) begin
        sh = {sh[22:0], mosi};
        cnt = cnt + 1;
        if (cnt == 16) begin
            ins = sh[15:8];
            adr = sh[7:0];
        end
        if (cnt == 24 && ins == 8'h02) mem[adr] = sh[7:0];
    end
    // released line shows a toggling value, not the last bit
    always @(negedge sck or posedge cs_n) begin
        if (!cs_n && cnt >= 16 && cnt < 24 && ins == 8'h03) miso <= mem[adr][23 - cnt];
        else miso <= ~miso;
    end
endmodule
`default_nettype wire

// ==== sim/eac_top_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module eac_top_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic cfg_done_r,
    input wire logic eep_cs_n,
    input wire logic eep_sck
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // frame length counter, wide enough to catch a stuck frame
    logic [8:0] low_cnt_r;
    always @(posedge aclk) begin
        if (!aresetn || eep_cs_n) low_cnt_r <= 9'h000;
        else if (low_cnt_r != 9'h1FF) low_cnt_r <= low_cnt_r + 9'h001;
    end
    property p_rst_idle; $rose(aresetn) |-> eep_cs_n && !eep_sck && !s_axi_bvalid && !s_axi_rvalid; endproperty
    property p_sck_idle; eep_cs_n |-> !eep_sck; endproperty
    property p_frame_len; $rose(eep_cs_n) |-> low_cnt_r >= 9'h0B9 && low_cnt_r <= 9'h0CD; endproperty
    property p_frame_max; low_cnt_r <= 9'h0CD; endproperty
    property p_sck_start; $fell(eep_cs_n) |-> (!eep_sck)[*3] ##[1:6] eep_sck; endproperty
    property p_gap; $rose(eep_cs_n) |=> eep_cs_n; endproperty
    property p_no_take; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_done_pulse; cfg_done_r |-> eep_cs_n ##1 !cfg_done_r; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
    a_sck_idle: assert property (p_sck_idle) else $error("sck not low outside frame");
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    a_frame_max: assert property (p_frame_max) else $error("frame runs too long");
    a_sck_start: assert property (p_sck_start) else $error("first sck edge misplaced");
    a_gap: assert property (p_gap) else $error("frame restarted at once");
    a_no_take: assert property (p_no_take) else $error("write taken during response");
    a_ar_block: assert property (p_ar_block) else $error("read taken during response");
    a_done_pulse: assert property (p_done_pulse) else $error("config done not a pulse");
    c_frame: cover property ($rose(eep_cs_n));
    c_cfg: cover property (cfg_done_r);
    c_rd: cover property (s_axi_rvalid);
endmodule
bind eac_top eac_top_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .cfg_done_r(cfg_done_r), .eep_cs_n(eep_cs_n), .eep_sck(eep_sck));
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, cfg_addr = 8'h00, cfg_wdata = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, st_req = 0, ld_req = 0;
    wire logic   awready, wready, bvalid, arready, rvalid, cfg_done, cs_n, sck, mosi, miso;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  cfg_rdata;
    int          miscompares = 0, samples_checked = 0, mem_m [0:255], a, d, n;
    logic [31:0] got;
    logic [1:0]  rs;
    int          done_cnt = 0;
    eac_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cfg_store_req(st_req), .cfg_load_req(ld_req), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata_r(cfg_rdata), .cfg_done_r(cfg_done), .eep_present_pin(1'b1),
        .eep_cs_n(cs_n), .eep_sck(sck), .eep_mosi(mosi), .eep_miso(miso));
    eac_eeprom_model mem_u (.cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
    initial forever #12.5 aclk = ~aclk;
    // every config completion pulse is counted
    always @(posedge aclk) if (cfg_done === 1'b1) done_cnt++;
    // ----------------------------------------
    // compares and bus tasks
    // ----------------------------------------
    task chk_data(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t data got %h exp %h", $time, g, e);
        end
    endtask
    task chk_resp(input logic [1:0] g, input logic [1:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t resp got %h exp %h", $time, g, e);
        end
    endtask
    // a missing answer is counted, so a hang shows up as a mismatch
    task wc(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= ad; wdata <= dt; awvalid <= 1; wvalid <= 1; bready <= 1; rs = 2'h3;
        for (int k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin
                rs = bresp;
                bready <= 0;
                break;
            end
        end
        chk_resp(rs, er);
    endtask
    task rc(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er, input bit cmp);
        @(posedge aclk);
        araddr <= ad; arvalid <= 1; rready <= 1; rs = 2'h3; got = 32'hDEAD;
        for (int k = 0; k < 64; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) begin
                rs = rresp;
                got = rdata;
                rready <= 0;
                break;
            end
        end
        if (cmp) chk_resp(rs, er);
        if (cmp) chk_data(got, e);
    endtask
    task poll_idle;
        for (n = 0; n < 300; n++) begin
            rc(8'h80, 0, 0, 0);
            if (got[11:9] === 3'h0) break;
        end
        chk_data({20'h0, got[11:8], 8'h0}, 32'h100);
    endtask
    task test_done;
        $display("counts: %0d compared, %0d mismatches", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #1000000;
        miscompares++;
        test_done;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        n = $urandom(32'h24641AEF);
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        rc(8'h84, 0, 0, 1);
        rc(8'h8C, 0, 0, 1);
        rc(8'h80, 32'h100, 0, 1);
        rc(8'h88, 0, 0, 1);
        rc(8'hFC, 0, 2, 1);
        wc(8'h00, 32'h55, 2);
        $display("test reset and map done");
        for (int i = 0; i < 4; i++) begin
            a = $urandom % 256;
            d = $urandom % 256;
            wc(8'h84, a, 0);
            wc(8'h8C, d, 0);
            wc(8'h88, 32'h4, 0);
            rc(8'h80, 32'h900, 0, 1);
            wc(8'h8C, ~d & 8'hFF, 0);
            poll_idle;
            mem_m[a] = d;
            rc(8'h8C, d, 0, 1);
            wc(8'h8C, 0, 0);
            wc(8'h88, 32'h8, 0);
            poll_idle;
            rc(8'h8C, mem_m[a], 0, 1);
            rc(8'h84, a, 0, 1);
        end
        $display("test program and read done");
        wc(8'h88, 32'h3, 0);
        rc(8'h80, 32'h100, 0, 1);
        $display("test bad opcode done");
        a = $urandom % 256;
        d = $urandom % 256;
        cfg_addr <= a; cfg_wdata <= d; st_req <= 1;
        @(posedge aclk);
        st_req <= 0;
        rc(8'h80, 32'hD00, 0, 1);
        wc(8'h88, 32'h8, 0);
        poll_idle;
        mem_m[a] = d;
        ld_req <= 1;
        @(posedge aclk);
        ld_req <= 0;
        rc(8'h80, 32'hB00, 0, 1);
        poll_idle;
        chk_data({24'h0, cfg_rdata}, mem_m[a]);
        wc(8'h84, a, 0);
        wc(8'h88, 32'h8, 0);
        poll_idle;
        rc(8'h8C, mem_m[a], 0, 1);
        chk_data(done_cnt, 32'h2);
        $display("test config commands done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(8'h84, 32'h0, 2'h0, 1'b1);
        rc(8'h8C, 32'h0, 2'h0, 1'b1);
        $display("test second reset done");
        test_done;
    end
endmodule
`default_nettype wire
